// file: input_select_eq_control.sv
`timescale 1ns/10ps
`include "input_select_eq_control_cfg.svh"

// Summary of operation
// - override bit 7 clear uses chooser pin; set lets bit 6 choose input.
// - bit 6 zero picks channel 0, one picks channel 1; both reset zero.
// - termination code bits 3:2 of channel 1 return tuning, reset 00.
// - forward impedance byte read/write, reset 0x00; software writes 0x70 for long cable.
// - bypass bit 6 applies manual level from register 0x04 instead of adaptation.
// - readback bits 7:4 show the equaliser level: thermometer when adapting, manual level in bypass; low nibble reads zero.
// - writing one to 0x01 bit 1 resets digital logic, registers kept; self clears.
// - losing lock returns equalizer to initial state and reruns acquisition.
module input_select_eq_control
    import isec_pkg::*;
#(
    parameter int EQ_STEP_CYCLES = `ISEC_EQ_STEP_CYC,
    parameter int SRST_CYCLES    = `ISEC_SRST_PULSE_CYC
)
(
    input  wire logic       core_clk_in,
    input  wire logic       reset_in,
    input  wire logic       power_down_pin_low_n_in,
    input  wire logic       channel_pick_pin_in,
    input  wire logic       link_locked_in,
    input  wire logic [7:0] reg_addr_in,
    input  wire logic [7:0] reg_wdata_in,
    input  wire logic       reg_wr_in,
    input  wire logic       reg_rd_in,
    output logic [7:0]      reg_rdata_out,
    output logic            reg_rvalid_out,
    output logic            secondary_serial_input_out,
    output logic [1:0]      termination_code_out,
    output logic [7:0]      fwd_impedance_out,
    output logic            eq_bypass_out,
    output logic [3:0]      eq_level_out,
    output logic            digital_reset_out
);

    // ------------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------------
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
        hit = (addr == ofs);
    endfunction

    // ------------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------------
    logic [2:0]  sync1_r;
    logic [2:0]  sync2_r;
    logic        pin_rst;
    logic        pick_pin;
    logic        locked;
    logic        locked_d_r;
    logic        lock_lost;

    logic [7:0]  term_r,     term_nxt;
    logic [7:0]  imped_r,    imped_nxt;
    logic [7:0]  chooser_r,  chooser_nxt;
    logic [7:0]  eqtest_r,   eqtest_nxt;
    logic [7:0]  manual_r,   manual_nxt;
    logic [3:0]  srst_cnt_r, srst_cnt_nxt;
    logic [7:0]  rdata_r,    rdata_nxt;
    logic        rvalid_r,   rvalid_nxt;
    logic        sel_r,      sel_nxt;
    logic        drst_r,     drst_nxt;
    logic [3:0]  level_r;
    isec_level_t tracker_level;
    logic        eq_restart_r, eq_restart_nxt;
    logic        srst_active;

    // ------------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------------
    always_ff @(posedge core_clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            sync1_r    <= 3'h0;
            sync2_r    <= 3'h0;
            locked_d_r <= 1'b0;
        end
        else
        begin
            sync1_r    <= {link_locked_in, channel_pick_pin_in, power_down_pin_low_n_in};
            sync2_r    <= sync1_r;
            locked_d_r <= sync2_r[2];
        end
    end

    assign pin_rst     = ~sync2_r[0];
    assign pick_pin    = sync2_r[1];
    assign locked      = sync2_r[2];
    assign lock_lost   = locked_d_r & ~locked;
    assign srst_active = (srst_cnt_r != 4'h0);

    // ------------------------------------------------------------------------
    // register file next state
    // ------------------------------------------------------------------------
    always_comb
    begin
        term_nxt     = term_r;
        imped_nxt    = imped_r;
        chooser_nxt  = chooser_r;
        eqtest_nxt   = eqtest_r;
        manual_nxt   = manual_r;
        srst_cnt_nxt = srst_cnt_r;
        rdata_nxt    = rdata_r;
        rvalid_nxt   = 1'b0;

        if (srst_active)
            srst_cnt_nxt = srst_cnt_r - 4'h1;

        if (reg_wr_in)
        begin
            if (hit(reg_addr_in, `ISEC_OFS_TERM_TUNE))
                term_nxt = reg_wdata_in;
            if (hit(reg_addr_in, `ISEC_OFS_IMPED_TUNE))
                imped_nxt = reg_wdata_in;
            if (hit(reg_addr_in, `ISEC_OFS_CHOOSER))
                chooser_nxt = reg_wdata_in;
            if (hit(reg_addr_in, `ISEC_OFS_EQ_TEST))
                eqtest_nxt = reg_wdata_in;
            if (hit(reg_addr_in, `ISEC_OFS_MANUAL_EQ))
                manual_nxt = reg_wdata_in;
            if (hit(reg_addr_in, `ISEC_OFS_SOFT_RESET) && reg_wdata_in[`ISEC_SRST_BIT])
                srst_cnt_nxt = 4'(SRST_CYCLES);
        end

        if (reg_rd_in)
        begin
            rvalid_nxt = 1'b1;
            rdata_nxt  = 8'h00;
            case (1'b1)
                hit(reg_addr_in, `ISEC_OFS_SOFT_RESET):
                    rdata_nxt[`ISEC_SRST_BIT] = srst_active;
                hit(reg_addr_in, `ISEC_OFS_MANUAL_EQ):
                    rdata_nxt = manual_r;
                hit(reg_addr_in, `ISEC_OFS_TERM_TUNE):
                    rdata_nxt = term_r;
                hit(reg_addr_in, `ISEC_OFS_IMPED_TUNE):
                    rdata_nxt = imped_r;
                hit(reg_addr_in, `ISEC_OFS_CHOOSER):
                    rdata_nxt = chooser_r;
                hit(reg_addr_in, `ISEC_OFS_EQ_TEST):
                    rdata_nxt = eqtest_r;
                hit(reg_addr_in, `ISEC_OFS_EQ_READBACK):
                    rdata_nxt = {level_r, 4'h0};
                default:
                    rdata_nxt = 8'h00;
            endcase
        end

        if (pin_rst)
        begin
            term_nxt     = `ISEC_RST_TERM_TUNE;
            imped_nxt    = `ISEC_RST_IMPED_TUNE;
            chooser_nxt  = `ISEC_RST_CHOOSER;
            eqtest_nxt   = `ISEC_RST_EQ_TEST;
            manual_nxt   = `ISEC_RST_MANUAL_EQ;
            srst_cnt_nxt = 4'h0;
        end
    end

    // ------------------------------------------------------------------------
    // control outputs next state
    // ------------------------------------------------------------------------
    always_comb
    begin
        if (chooser_r[`ISEC_OVERRIDE_BIT])
            sel_nxt = chooser_r[`ISEC_CHANNEL_BIT];
        else
            sel_nxt = pick_pin;
        drst_nxt       = pin_rst | srst_active;
        eq_restart_nxt = lock_lost | pin_rst | srst_active;
    end

    // ------------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------------
    always_ff @(posedge core_clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            term_r       <= `ISEC_RST_TERM_TUNE;
            imped_r      <= `ISEC_RST_IMPED_TUNE;
            chooser_r    <= `ISEC_RST_CHOOSER;
            eqtest_r     <= `ISEC_RST_EQ_TEST;
            manual_r     <= `ISEC_RST_MANUAL_EQ;
            srst_cnt_r   <= 4'h0;
            rdata_r      <= 8'h00;
            rvalid_r     <= 1'b0;
            sel_r        <= 1'b0;
            drst_r       <= 1'b1;
            eq_restart_r <= 1'b1;
            level_r      <= `ISEC_LEVEL_MIN;
        end
        else
        begin
            term_r       <= term_nxt;
            imped_r      <= imped_nxt;
            chooser_r    <= chooser_nxt;
            eqtest_r     <= eqtest_nxt;
            manual_r     <= manual_nxt;
            srst_cnt_r   <= srst_cnt_nxt;
            rdata_r      <= rdata_nxt;
            rvalid_r     <= rvalid_nxt;
            sel_r        <= sel_nxt;
            drst_r       <= drst_nxt;
            eq_restart_r <= eq_restart_nxt;
            level_r      <= tracker_level;
        end
    end

    // ------------------------------------------------------------------------
    // equaliser level tracker
    // ------------------------------------------------------------------------
    isec_eq_tracker #(
        .STEP_CYCLES (EQ_STEP_CYCLES)
    ) u_eq_tracker (
        .core_clk_in     (core_clk_in),
        .reset_in        (reset_in),
        .restart_in      (eq_restart_r),
        .locked_in       (locked),
        .bypass_in       (eqtest_r[`ISEC_BYPASS_BIT]),
        .manual_level_in (manual_r[`ISEC_LEVEL_HI:`ISEC_LEVEL_LO]),
        .level_out       (tracker_level)
    );

    // ------------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------------
    assign reg_rdata_out              = rdata_r;
    assign reg_rvalid_out             = rvalid_r;
    assign secondary_serial_input_out = sel_r;
    assign termination_code_out       = term_r[`ISEC_TERM_HI:`ISEC_TERM_LO];
    assign fwd_impedance_out          = imped_r;
    assign eq_bypass_out              = eqtest_r[`ISEC_BYPASS_BIT];
    assign eq_level_out               = level_r;
    assign digital_reset_out          = drst_r;

endmodule // input_select_eq_control

// file: input_select_eq_control_cfg.svh
`ifndef INPUT_SELECT_EQ_CONTROL_CFG_SVH
`define INPUT_SELECT_EQ_CONTROL_CFG_SVH

// ----------------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------------
`define ISEC_OFS_SOFT_RESET   8'h01
`define ISEC_OFS_MANUAL_EQ    8'h04
`define ISEC_OFS_TERM_TUNE    8'h46
`define ISEC_OFS_IMPED_TUNE   8'h47
`define ISEC_OFS_CHOOSER      8'h4c
`define ISEC_OFS_EQ_TEST      8'h4d
`define ISEC_OFS_EQ_READBACK  8'h4e

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define ISEC_SRST_BIT         1
`define ISEC_OVERRIDE_BIT     7
`define ISEC_CHANNEL_BIT      6
`define ISEC_BYPASS_BIT       6
`define ISEC_TERM_HI          3
`define ISEC_TERM_LO          2
`define ISEC_LEVEL_HI         7
`define ISEC_LEVEL_LO         4

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define ISEC_RST_TERM_TUNE    8'h00
`define ISEC_RST_IMPED_TUNE   8'h00
`define ISEC_RST_CHOOSER      8'h00
`define ISEC_RST_EQ_TEST      8'h20
`define ISEC_RST_MANUAL_EQ    8'h00
`define ISEC_LEVEL_MIN        4'h0
`define ISEC_LEVEL_MAX        4'hf

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define ISEC_CLK_PERIOD_NS    10
`define ISEC_SRST_PULSE_CYC   4
`define ISEC_EQ_STEP_NS       1000
`define ISEC_EQ_STEP_CYC      (`ISEC_EQ_STEP_NS / `ISEC_CLK_PERIOD_NS)

`endif

// file: isec_pkg.sv
package isec_pkg;

    typedef enum logic [1:0]
    {
        ISEC_ACQUIRE = 2'b01,
        ISEC_LOCKED  = 2'b10
    } isec_eq_state_e;

    typedef logic [3:0] isec_level_t;

endpackage

// file: isec_eq_tracker.sv
`timescale 1ns/10ps
`include "input_select_eq_control_cfg.svh"

module isec_eq_tracker
    import isec_pkg::*;
#(
    parameter int STEP_CYCLES = `ISEC_EQ_STEP_CYC
)
(
    input  wire logic        core_clk_in,
    input  wire logic        reset_in,
    input  wire logic        restart_in,
    input  wire logic        locked_in,
    input  wire logic        bypass_in,
    input  wire isec_level_t manual_level_in,
    output isec_level_t      level_out
);

    isec_eq_state_e state_r, state_nxt;
    isec_level_t    adapt_r, adapt_nxt;
    isec_level_t    level_r, level_nxt;
    logic [15:0]    div_r, div_nxt;
    logic           tick;

    // ------------------------------------------------------------------------
    // step divider and acquisition walk
    // ------------------------------------------------------------------------
    always_comb
    begin
        tick      = (div_r == 16'(STEP_CYCLES - 1));
        div_nxt   = tick ? 16'h0000 : div_r + 16'h0001;
        state_nxt = state_r;
        adapt_nxt = adapt_r;
        case (state_r)
            ISEC_ACQUIRE:
            begin
                if (tick)
                begin
                    if (locked_in)
                        state_nxt = ISEC_LOCKED;
                    else if (adapt_r == `ISEC_LEVEL_MAX)
                        adapt_nxt = `ISEC_LEVEL_MIN;
                    else
                        adapt_nxt = {adapt_r[2:0], 1'b1};
                end
            end
            ISEC_LOCKED:
            begin
                if (!locked_in)
                begin
                    state_nxt = ISEC_ACQUIRE;
                    adapt_nxt = `ISEC_LEVEL_MIN;
                end
            end
            default:
            begin
                state_nxt = ISEC_ACQUIRE;
                adapt_nxt = `ISEC_LEVEL_MIN;
            end
        endcase
        if (restart_in)
        begin
            state_nxt = ISEC_ACQUIRE;
            adapt_nxt = `ISEC_LEVEL_MIN;
            div_nxt   = 16'h0000;
        end
        level_nxt = bypass_in ? manual_level_in : adapt_nxt;
    end

    always_ff @(posedge core_clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            state_r <= ISEC_ACQUIRE;
            adapt_r <= `ISEC_LEVEL_MIN;
            level_r <= `ISEC_LEVEL_MIN;
            div_r   <= 16'h0000;
        end
        else
        begin
            state_r <= state_nxt;
            adapt_r <= adapt_nxt;
            level_r <= level_nxt;
            div_r   <= div_nxt;
        end
    end

    assign level_out = level_r;

endmodule // isec_eq_tracker

// file: input_select_eq_control_checker.sv
`timescale 1ns/10ps
module isec_checker
    import isec_pkg::*;
(
    input wire logic       core_clk_in,
    input wire logic       reset_in,
    input wire logic       power_down_pin_low_n_in,
    input wire logic       link_locked_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic       reg_wr_in,
    input wire logic       reg_rd_in,
    input wire logic [7:0] reg_rdata_out,
    input wire logic       reg_rvalid_out,
    input wire logic       secondary_serial_input_out,
    input wire logic [1:0] termination_code_out,
    input wire logic [7:0] fwd_impedance_out,
    input wire logic       eq_bypass_out,
    input wire logic [3:0] eq_level_out,
    input wire logic       digital_reset_out
);
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (reset_in);
    sequence s_wr(logic [7:0] a);
        reg_wr_in && reg_addr_in == a && power_down_pin_low_n_in;
    endsequence
    sequence s_rst_held;
        digital_reset_out [*3];
    endsequence
    property p_rd_answer;
        reg_rd_in |=> reg_rvalid_out;
    endproperty
    property p_answer_cause;
        reg_rvalid_out |-> $past(reg_rd_in);
    endproperty
    property p_sel_override;
        s_wr(8'h4c) ##0 reg_wdata_in[7] |-> ##2
            secondary_serial_input_out == $past(reg_wdata_in[6], 2);
    endproperty
    property p_term;
        s_wr(8'h46) |=> termination_code_out == $past(reg_wdata_in[3:2]);
    endproperty
    property p_imped;
        s_wr(8'h47) |=> fwd_impedance_out == $past(reg_wdata_in);
    endproperty
    property p_bypass;
        s_wr(8'h4d) |=> eq_bypass_out == $past(reg_wdata_in[6]);
    endproperty
    property p_level_rd;
        reg_rd_in && reg_addr_in == 8'h4e |=> reg_rdata_out[3:0] == 4'h0;
    endproperty
    property p_thermo;
        !eq_bypass_out && $past(!eq_bypass_out, 3) |->
            eq_level_out inside {4'h0, 4'h1, 4'h3, 4'h7, 4'hf};
    endproperty
    property p_soft_reset;
        s_wr(8'h01) ##0 reg_wdata_in[1] |-> ##3 s_rst_held;
    endproperty
    property p_lock_loss;
        $fell(link_locked_in) && !eq_bypass_out |-> ##[1:6] eq_level_out == 4'h0;
    endproperty
    property p_pin_reset;
        !power_down_pin_low_n_in [*4] |=> digital_reset_out && fwd_impedance_out == 8'h00
            && termination_code_out == 2'b00 && !eq_bypass_out;
    endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
    a_answer_cause: assert property (p_answer_cause) else $error("stray rvalid");
    a_sel_override: assert property (p_sel_override) else $error("sel wrong");
    a_term: assert property (p_term) else $error("termination wrong");
    a_imped: assert property (p_imped) else $error("impedance wrong");
    a_bypass: assert property (p_bypass) else $error("bypass wrong");
    a_level_rd: assert property (p_level_rd) else $error("low nibble set");
    a_thermo: assert property (p_thermo) else $error("level not thermometer");
    a_soft_reset: assert property (p_soft_reset) else $error("soft reset short");
    a_lock_loss: assert property (p_lock_loss) else $error("eq not restarted");
    a_pin_reset: assert property (p_pin_reset) else $error("pin reset wrong");
endmodule // isec_checker

bind input_select_eq_control isec_checker chk_u (.*);

// file: isec_link_partner.sv
`timescale 1ns/10ps
module isec_link_partner
#(
    parameter int LOCK_DLY = 6
)
(
    input  wire logic core_clk_in,
    input  wire logic send_in,
    output logic      locked_out
);
    int cnt_r;
    // lock drops at once when the stream stops, returns after a delay
    always_ff @(posedge core_clk_in)
    begin
        if (!send_in)
            cnt_r <= 0;
        else if (cnt_r < LOCK_DLY)
            cnt_r <= cnt_r + 1;
    end
    assign locked_out = (cnt_r == LOCK_DLY);
endmodule // isec_link_partner

// file: tb_input_select_eq_control.sv
`timescale 1ns/10ps
module tb_input_select_eq_control;
    import isec_pkg::*;
    logic clk = 0, rst = 1, pin_n = 1, pick = 0, send = 1, wr = 0, rd = 0;
    logic [7:0] addr = 8'h00, wd = 8'h00, rdata, imp;
    logic rvalid, sel, byp, drst, locked;
    logic [1:0] term;
    logic [3:0] lvl;
    int n_errors = 0, compares = 0;
    always #5 clk = ~clk;
    isec_link_partner lp_u (.core_clk_in(clk), .send_in(send), .locked_out(locked));
    input_select_eq_control #(.EQ_STEP_CYCLES(4)) dut_u (.core_clk_in(clk), .reset_in(rst),
        .power_down_pin_low_n_in(pin_n), .channel_pick_pin_in(pick), .link_locked_in(locked),
        .reg_addr_in(addr), .reg_wdata_in(wd), .reg_wr_in(wr), .reg_rd_in(rd),
        .reg_rdata_out(rdata), .reg_rvalid_out(rvalid), .secondary_serial_input_out(sel),
        .termination_code_out(term), .fwd_impedance_out(imp), .eq_bypass_out(byp),
        .eq_level_out(lvl), .digital_reset_out(drst));
    task automatic chk(string nm, logic [7:0] exp, logic [7:0] got);
        compares++;
        if (got !== exp)
        begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic cyc(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wrt(logic [7:0] a, logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wd <= d;
        wr <= 1;
        @(posedge clk);
        wr <= 0;
    endtask
    task automatic rdc(logic [7:0] a, logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1;
        @(posedge clk);
        rd <= 0;
        #1;
        chk("rvalid", 8'h01, {7'h0, rvalid});
        chk("rdata", exp, rdata);
    endtask
    task automatic t_reset_values;
        rdc(8'h46, 8'h00);
        rdc(8'h47, 8'h00);
        rdc(8'h4c, 8'h00);
        rdc(8'h4d, 8'h20);
        rdc(8'h04, 8'h00);
        rdc(8'h01, 8'h00);
        rdc(8'h50, 8'h00);
        $display("test reset_values done");
    endtask
    task automatic t_select;
        pick <= 1;
        cyc(5);
        chk("sel pin", 8'h01, {7'h0, sel});
        wrt(8'h4c, 8'h80);
        cyc(3);
        chk("sel reg0", 8'h00, {7'h0, sel});
        pick <= 0;
        wrt(8'h4c, 8'hc0);
        cyc(5);
        chk("sel reg1", 8'h01, {7'h0, sel});
        wrt(8'h4c, 8'h00);
        cyc(5);
        chk("sel back", 8'h00, {7'h0, sel});
        $display("test select done");
    endtask
    task automatic t_tuning;
        for (int c = 0; c < 4; c++)
        begin
            wrt(8'h46, 8'(c << 2));
            cyc(1);
            chk("term", 8'(c), {6'h0, term});
            rdc(8'h46, 8'(c << 2));
        end
        wrt(8'h47, 8'h70);
        cyc(1);
        chk("imped", 8'h70, imp);
        rdc(8'h47, 8'h70);
        $display("test tuning done");
    endtask
    task automatic t_bypass;
        wrt(8'h04, 8'h70);
        wrt(8'h4d, 8'h60);
        cyc(3);
        chk("bypass", 8'h01, {7'h0, byp});
        chk("manual lvl", 8'h07, {4'h0, lvl});
        rdc(8'h4e, 8'h70);
        wrt(8'h4d, 8'h20);
        $display("test bypass done");
    endtask
    task automatic t_lock;
        logic seen0;
        seen0 = 0;
        send <= 0;
        for (int i = 0; i < 7; i++)
        begin
            cyc(1);
            seen0 |= (lvl === 4'h0);
        end
        chk("eq restart", 8'h01, {7'h0, seen0});
        // walk length makes the equaliser regain lock at a nonzero level
        for (int i = 0; i < 28; i++)
        begin
            cyc(1);
            chk("thermo", 8'h01, {7'h0, lvl inside {4'h0, 4'h1, 4'h3, 4'h7, 4'hf}});
        end
        send <= 1;
        cyc(20);
        chk("eq held", 8'h01, {7'h0, lvl inside {4'h1, 4'h3, 4'h7, 4'hf}});
        // second loss starts from a nonzero level, so the return to zero is real
        seen0 = 0;
        send <= 0;
        for (int i = 0; i < 7; i++)
        begin
            cyc(1);
            seen0 |= (lvl === 4'h0);
        end
        chk("eq rerun", 8'h01, {7'h0, seen0});
        send <= 1;
        cyc(20);
        $display("test lock done");
    endtask
    task automatic t_soft_reset;
        wrt(8'h46, 8'h0c);
        wrt(8'h01, 8'h02);
        rdc(8'h01, 8'h02);
        chk("drst", 8'h01, {7'h0, drst});
        cyc(6);
        chk("drst off", 8'h00, {7'h0, drst});
        rdc(8'h01, 8'h00);
        rdc(8'h46, 8'h0c);
        $display("test soft_reset done");
    endtask
    task automatic t_pin_reset;
        // host resets after lock loss; low time shortened for simulation
        pin_n <= 0;
        cyc(10);
        chk("pin drst", 8'h01, {7'h0, drst});
        pin_n <= 1;
        cyc(6);
        rdc(8'h46, 8'h00);
        rdc(8'h47, 8'h00);
        $display("test pin_reset done");
    endtask
    task automatic finish_test;
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial
    begin
        #200us;
        n_errors++;
        finish_test();
    end
    initial
    begin
        cyc(4);
        rst <= 0;
        cyc(6);
        t_reset_values();
        t_select();
        t_tuning();
        t_bypass();
        t_lock();
        t_soft_reset();
        t_pin_reset();
        finish_test();
    end
endmodule // tb_input_select_eq_control
